/* src/msp_regs.svh */
// Register offsets, command values and field positions of the motion sensor serial port
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH

`define MSP_ADDR_PRODUCT_ID   7'h00
`define MSP_ADDR_REVISION_ID  7'h01
`define MSP_ADDR_MOTION       7'h02
`define MSP_ADDR_DELTA_X_L    7'h03
`define MSP_ADDR_DELTA_Y_L    7'h04
`define MSP_ADDR_XY_SHIFT_H   7'h05
`define MSP_ADDR_SURF_QUAL    7'h06
`define MSP_ADDR_SHUT_UPPER   7'h07
`define MSP_ADDR_SHUT_LOWER   7'h08
`define MSP_ADDR_PEAK_PIXEL   7'h09
`define MSP_ADDR_INIT_CMD     7'h3a
`define MSP_ADDR_SHUTDOWN_CMD 7'h3b
`define MSP_ADDR_BURST        7'h42

`define MSP_INIT_VALUE        8'h5a
`define MSP_SHUTDOWN_VALUE    8'he7

`define MSP_DIR_BIT           7
`define MSP_STAT_MOVED_BIT    7
`define MSP_STAT_OVERRUN_BIT  4

`define MSP_BURST_LAST        3'h7
`define MSP_BIT_LAST          3'h7

`endif

/* src/msp_pkg.sv */
// Types shared by the motion sensor serial port
package msp_pkg;

   // Power state of the sensor core, one-hot
   typedef enum logic [2:0] {
      MSP_PWR_UNINIT = 3'b001,
      MSP_PWR_RUN    = 3'b010,
      MSP_PWR_SHUT   = 3'b100
   } msp_pwr_t;

   typedef logic [7:0]  msp_byte_t;
   typedef logic [6:0]  msp_addr_t;
   typedef logic [11:0] msp_delta_t;

endpackage

/* src/msp_serial_port.sv */
// Serial slave port and register file of the optical motion sensor
//
// What this block and its host must do
// (RQ1) Port works only while select is low; raising select aborts and resets it.
// (RQ2) Host keeps normal inter-transaction delay even after an abort.
// (RQ3) Host frames every transaction with select and idles deselected.
// (RQ4) Write is address byte with direction bit 1, then one data byte.
// (RQ5) Input sampled on rising clock edges; output changes on falling edges.
// (RQ6) Read is address byte with direction bit 0, then device drives data byte.
// (RQ7) Last read bit held on output until the next falling clock edge.
// (RQ8) Host respects write-to-write delay before second write's last data bit.
// (RQ9) Host respects write-to-read delay before read's last address bit.
// (RQ10) Host pauses clock for read address-to-data delay after address.
// (RQ11) Host waits read-to-read or read-to-write delay after a read.
// (RQ12) Reading burst register streams eight motion bytes in fixed order.
// (RQ13) Host may end burst after delta X byte by raising select.
// (RQ14) Burst data latched after address; bytes then clocked without gaps. Only status latched there, later bytes fetched while previous shifts.
// (RQ15) After burst, port refuses all transactions until select goes high.
// (RQ16) No self reset at power-up; init value written to init register.
// (RQ17) Host power-up sequence: toggle select, init, observation check, reads.
// (RQ18) Host finishes init with seven fixed configuration writes in order.
// (RQ19) Writing shutdown value to shutdown register enters shutdown.
// (RQ20) In shutdown only the init write is obeyed; inputs ignored when deselected.
// (RQ21) Host leaves shutdown by repeating init and reloading settings.
// (RQ22) In shutdown emitter outputs are high; data and motion keep state.
// (RQ23) Deselected: inputs ignored and data output released to high impedance.
// (RQ24) Motion output low while moved flag set; released by reads or write.
// (RQ25) Write to motion register clears flags and deltas, byte not stored.
// (RQ26) Select high resets bit counter and burst state.
// (RQ27) Serial clock and select events synchronised into the core clock.
`timescale 1ns/1ps
`include "msp_regs.svh"

module msp_serial_port #(
   parameter logic [7:0] PRODUCT_ID  = 8'h5c, // Arbitrary identification value
   parameter logic [7:0] REVISION_ID = 8'h01  // Arbitrary identification value
) (
   input  wire logic              core_clk,        // Internal oscillator clock, 50 MHz
   input  wire logic              sys_rst,         // Synchronous reset, active high
   input  wire logic              serial_clk,      // Host serial clock, own domain
   input  wire logic              chip_select_n,   // Port select, active low
   input  wire logic              mosi_in,         // Host data in
   output logic                   miso_out,        // Device data out
   output logic                   miso_oe,         // Data out enable, high drives
   output logic                   motion_n,        // Motion pending, active low
   output logic                   emitter_enable_n,// Emitter enable, active low
   output logic                   emitter_drive,   // Emitter drive, high is off
   input  wire logic              emitter_request, // Imaging core wants light
   input  wire logic              motion_valid,    // New displacement sample
   input  wire msp_pkg::msp_delta_t motion_dx,     // Signed X displacement
   input  wire msp_pkg::msp_delta_t motion_dy,     // Signed Y displacement
   input  wire msp_pkg::msp_byte_t surface_quality,// Image quality byte
   input  wire msp_pkg::msp_byte_t shutter_upper,  // Shutter high byte
   input  wire msp_pkg::msp_byte_t shutter_lower,  // Shutter low byte
   input  wire msp_pkg::msp_byte_t peak_pixel,     // Brightest pixel
   output msp_pkg::msp_pwr_t      power_state      // Current power state
);
   import msp_pkg::*;

   // ---------------- Serial clock domain ----------------
   logic [2:0] bit_cnt_reg;     // Bit within current byte
   logic [6:0] rx_sh_reg;       // Incoming bits
   logic       data_phase_reg;  // Address byte done
   logic       wr_done_reg;     // Write data byte taken
   msp_addr_t  addr_reg;        // Latched address
   logic       is_write_reg;    // Direction of transaction
   msp_byte_t  wr_data_reg;     // Latched write byte
   logic       addr_tgl_reg;    // Event: address byte done
   logic       wr_tgl_reg;      // Event: write byte done
   logic [2:0] tx_cnt_reg;      // Bit within outgoing byte
   msp_byte_t  tx_sh_reg;       // Outgoing shifter
   logic       ld_tgl_reg;      // Event: output byte loaded
   msp_byte_t  tx_hold_reg;     // Core-side byte offered to shifter

   // (RQ26) Select reset bit counter
   // (RQ1) Abort on select high
   // (RQ5) Rising edge sampling
   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt_reg    <= 3'h0;
         rx_sh_reg      <= 7'h00;
         data_phase_reg <= 1'b0;
         wr_done_reg    <= 1'b0;
         addr_reg       <= 7'h00;
         is_write_reg   <= 1'b0;
         wr_data_reg    <= 8'h00;
         addr_tgl_reg   <= 1'b0;
         wr_tgl_reg     <= 1'b0;
      end else begin
         rx_sh_reg   <= {rx_sh_reg[5:0], mosi_in};
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == `MSP_BIT_LAST) begin
            if (!data_phase_reg) begin
               // (RQ4) Direction bit then address
               is_write_reg   <= rx_sh_reg[6];
               addr_reg       <= {rx_sh_reg[5:0], mosi_in};
               data_phase_reg <= 1'b1;
               addr_tgl_reg   <= ~addr_tgl_reg;
            end else if (is_write_reg && !wr_done_reg) begin
               // Only the first data byte of a write counts
               wr_data_reg <= {rx_sh_reg, mosi_in};
               wr_done_reg <= 1'b1;
               wr_tgl_reg  <= ~wr_tgl_reg;
            end
         end
      end
   end

   // (RQ6) Read byte driven after the address
   // (RQ5) Output shifts on falling edges
   // (RQ7) Bit held until next falling edge
   // (RQ14) Byte taken from holding latch
   always_ff @(negedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         tx_cnt_reg <= 3'h0;
         tx_sh_reg  <= 8'h00;
         ld_tgl_reg <= 1'b0;
      end else if (data_phase_reg && !is_write_reg) begin
         tx_cnt_reg <= tx_cnt_reg + 3'h1;
         if (tx_cnt_reg == 3'h0) begin
            // Holding latch is stable here: host paused after the address
            tx_sh_reg  <= tx_hold_reg;
            ld_tgl_reg <= ~ld_tgl_reg;
         end else begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
      end
   end

   // (RQ23) Released while deselected
   assign miso_oe  = ~chip_select_n;
   assign miso_out = tx_sh_reg[7];

   // ---------------- Core clock domain ----------------
   logic [1:0] cs_sync_reg;     // Select synchroniser
   logic [3:0] addr_sync_reg;   // Address event synchroniser plus history
   logic [3:0] wr_sync_reg;     // Write event synchroniser plus history
   logic [3:0] ld_sync_reg;     // Load event synchroniser plus history

   // (RQ27) Two-flop synchronisers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cs_sync_reg   <= 2'b11;
         addr_sync_reg <= 4'h0;
         wr_sync_reg   <= 4'h0;
         ld_sync_reg   <= 4'h0;
      end else begin
         cs_sync_reg   <= {cs_sync_reg[0], chip_select_n};
         addr_sync_reg <= {addr_sync_reg[2:0], addr_tgl_reg};
         wr_sync_reg   <= {wr_sync_reg[2:0], wr_tgl_reg};
         ld_sync_reg   <= {ld_sync_reg[2:0], ld_tgl_reg};
      end
   end

   // Events are judged one stage late so the select reset never looks like one
   logic cs_hi;
   logic addr_ev;
   logic wr_ev;
   logic ld_ev;
   assign cs_hi   = cs_sync_reg[1];
   assign addr_ev = ~cs_hi & (addr_sync_reg[3] ^ addr_sync_reg[2]);
   assign wr_ev   = ~cs_hi & (wr_sync_reg[3] ^ wr_sync_reg[2]);
   assign ld_ev   = ~cs_hi & (ld_sync_reg[3] ^ ld_sync_reg[2]);

   msp_pwr_t   pwr_reg;         // Power state
   logic       burst_act_reg;   // Burst streaming
   logic       burst_lock_reg;  // Burst started, waiting for select high
   logic [2:0] burst_idx_reg;   // Burst byte now in holding latch
   logic       moved_flag;      // Motion pending
   logic       accumulator_overrun; // Delta overflowed
   msp_delta_t acc_x_reg;       // Accumulated X
   msp_delta_t acc_y_reg;       // Accumulated Y
   logic       rd_x_reg;        // Delta X read since motion
   logic       rd_y_reg;        // Delta Y read since motion
   msp_byte_t  mem [0:127];     // Plain read/write registers

   // Decoded write
   logic wr_ok;
   logic wr_init;
   logic wr_shut;
   logic wr_motion;
   assign wr_init   = (addr_reg == `MSP_ADDR_INIT_CMD) && (wr_data_reg == `MSP_INIT_VALUE);
   // (RQ20) Shutdown obeys only init
   assign wr_ok     = wr_ev && is_write_reg && !burst_lock_reg
                      && (pwr_reg != MSP_PWR_SHUT || wr_init);
   assign wr_shut   = wr_ok && (addr_reg == `MSP_ADDR_SHUTDOWN_CMD)
                      && (wr_data_reg == `MSP_SHUTDOWN_VALUE);
   assign wr_motion = wr_ok && (addr_reg == `MSP_ADDR_MOTION);

   // Byte fetch for the output latch
   logic      fetch_en;
   msp_addr_t fetch_addr;
   always_comb begin
      fetch_en   = 1'b0;
      fetch_addr = addr_reg;
      if (addr_ev && !is_write_reg && !burst_lock_reg && pwr_reg != MSP_PWR_SHUT) begin
         fetch_en = 1'b1;
         // (RQ12) Burst opens with motion status
         if (addr_reg == `MSP_ADDR_BURST) begin
            fetch_addr = `MSP_ADDR_MOTION;
         end
      end else if (ld_ev && burst_act_reg && burst_idx_reg != `MSP_BURST_LAST) begin
         // (RQ14) Next byte prefetched during current
         fetch_en   = 1'b1;
         fetch_addr = `MSP_ADDR_MOTION + 7'(burst_idx_reg) + 7'h01;
      end
   end

   // Read multiplexer
   msp_byte_t rd_byte;
   always_comb begin
      unique case (fetch_addr)
         `MSP_ADDR_PRODUCT_ID:  rd_byte = PRODUCT_ID;
         `MSP_ADDR_REVISION_ID: rd_byte = REVISION_ID;
         `MSP_ADDR_MOTION: begin
            rd_byte = 8'h00;
            rd_byte[`MSP_STAT_MOVED_BIT]   = moved_flag;
            rd_byte[`MSP_STAT_OVERRUN_BIT] = accumulator_overrun;
         end
         `MSP_ADDR_DELTA_X_L:   rd_byte = acc_x_reg[7:0];
         `MSP_ADDR_DELTA_Y_L:   rd_byte = acc_y_reg[7:0];
         `MSP_ADDR_XY_SHIFT_H:  rd_byte = {acc_x_reg[11:8], acc_y_reg[11:8]};
         `MSP_ADDR_SURF_QUAL:   rd_byte = surface_quality;
         `MSP_ADDR_SHUT_UPPER:  rd_byte = shutter_upper;
         `MSP_ADDR_SHUT_LOWER:  rd_byte = shutter_lower;
         `MSP_ADDR_PEAK_PIXEL:  rd_byte = peak_pixel;
         default:               rd_byte = mem[fetch_addr];
      endcase
   end

   // Output holding latch; left alone when nothing is fetched
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_hold_reg <= 8'h00;
      end else if (fetch_en) begin
         tx_hold_reg <= rd_byte;
      end
   end

   // Burst sequencing
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         burst_act_reg  <= 1'b0;
         burst_lock_reg <= 1'b0;
         burst_idx_reg  <= 3'h0;
      end else if (cs_hi) begin
         // (RQ15) Select high releases lock
         // (RQ13) Select high ends burst
         burst_act_reg  <= 1'b0;
         burst_lock_reg <= 1'b0;
         burst_idx_reg  <= 3'h0;
      end else if (fetch_en && addr_ev && addr_reg == `MSP_ADDR_BURST) begin
         // (RQ12) Burst register read starts burst
         // (RQ15) Lock until select high
         burst_act_reg  <= 1'b1;
         burst_lock_reg <= 1'b1;
         burst_idx_reg  <= 3'h0;
      end else if (ld_ev && burst_act_reg) begin
         // First load carries byte 0; index tracks byte in holding latch
         if (burst_idx_reg == `MSP_BURST_LAST) begin
            burst_act_reg <= 1'b0;
         end else begin
            burst_idx_reg <= burst_idx_reg + 3'h1;
         end
      end
   end

   // Power state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pwr_reg <= MSP_PWR_UNINIT;
      end else if (wr_ok && wr_init) begin
         // (RQ16) Init command starts core
         pwr_reg <= MSP_PWR_RUN;
      end else if (wr_shut) begin
         // (RQ19) Shutdown command
         pwr_reg <= MSP_PWR_SHUT;
      end
   end
   assign power_state = pwr_reg;

   // Motion accumulation and clearing
   logic [12:0] sum_x;
   logic [12:0] sum_y;
   logic        ovf_x;
   logic        ovf_y;
   logic        rd_clear;
   assign sum_x    = {acc_x_reg[11], acc_x_reg} + {motion_dx[11], motion_dx};
   assign sum_y    = {acc_y_reg[11], acc_y_reg} + {motion_dy[11], motion_dy};
   assign ovf_x    = sum_x[12] ^ sum_x[11];
   assign ovf_y    = sum_y[12] ^ sum_y[11];
   assign rd_clear = fetch_en && moved_flag
                     && ((fetch_addr == `MSP_ADDR_DELTA_X_L && rd_y_reg)
                     || (fetch_addr == `MSP_ADDR_DELTA_Y_L && rd_x_reg));

   always_ff @(posedge core_clk) begin
      if (sys_rst || (wr_ok && wr_init)) begin
         moved_flag          <= 1'b0;
         accumulator_overrun <= 1'b0;
         acc_x_reg           <= 12'h000;
         acc_y_reg           <= 12'h000;
         rd_x_reg            <= 1'b0;
         rd_y_reg            <= 1'b0;
      end else if (motion_valid && pwr_reg == MSP_PWR_RUN && !accumulator_overrun) begin
         // New motion wins over a motion write or delta-read clear in the same cycle; an init write still wins over it
         moved_flag          <= 1'b1;
         accumulator_overrun <= ovf_x | ovf_y;
         acc_x_reg           <= sum_x[11:0];
         acc_y_reg           <= sum_y[11:0];
         rd_x_reg            <= 1'b0;
         rd_y_reg            <= 1'b0;
      end else if (wr_motion || rd_clear) begin
         // (RQ25) Motion write clears flags, deltas
         // (RQ24) Delta reads release motion
         moved_flag          <= 1'b0;
         accumulator_overrun <= 1'b0;
         acc_x_reg           <= 12'h000;
         acc_y_reg           <= 12'h000;
         rd_x_reg            <= 1'b0;
         rd_y_reg            <= 1'b0;
      end else if (fetch_en && moved_flag) begin
         if (fetch_addr == `MSP_ADDR_DELTA_X_L) begin
            rd_x_reg <= 1'b1;
         end
         if (fetch_addr == `MSP_ADDR_DELTA_Y_L) begin
            rd_y_reg <= 1'b1;
         end
      end
   end

   // Plain register storage, one entry per generate step
   genvar gi;
   generate
      for (gi = 0; gi < 128; gi++) begin : g_mem
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               mem[gi] <= 8'h00;
            end else if (wr_ok && addr_reg == 7'(gi) && !wr_motion) begin
               // (RQ25) Motion write not stored
               mem[gi] <= wr_data_reg;
            end
         end
      end
   endgenerate

   // Motion pin and emitter outputs from flops
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         motion_n         <= 1'b1;
         emitter_enable_n <= 1'b1;
         emitter_drive    <= 1'b1;
      end else begin
         // (RQ24) Motion pin follows flag
         // (RQ22) Motion pin frozen in shutdown
         if (pwr_reg != MSP_PWR_SHUT) begin
            motion_n <= ~moved_flag;
         end
         // (RQ22) Emitter off in shutdown
         emitter_enable_n <= ~(pwr_reg == MSP_PWR_RUN && emitter_request);
         emitter_drive    <= ~(pwr_reg == MSP_PWR_RUN && emitter_request);
      end
   end

endmodule // msp_serial_port

/* tb/msp_host_model.sv */
// Host master model driving the four-wire serial link
`timescale 1ns/1ps

module msp_host_model (
   output logic      serial_clk,    // Link clock, idles high
   output logic      chip_select_n, // Select, active low
   output logic      mosi_in,       // Host data
   input  wire logic miso_out       // Device data
);
   localparam int HALF = 40; // Half of the 80 ns link period

   // Idle: deselected, clock parked high
   initial begin
      serial_clk    = 1'b1;
      chip_select_n = 1'b1;
      mosi_in       = 1'b0;
   end

   task automatic frame(input logic lvl);
      // Odd offset keeps link edges drifting against the core clock
      #(2 * HALF + 7) chip_select_n = lvl;
      #(2 * HALF);
   endtask

   // MSB first, host changes data on falls
   task automatic send(input logic [7:0] b, input int gap);
      for (int i = 7; i >= 0; i--) begin
         serial_clk = 1'b0;
         mosi_in    = b[i];
         #HALF serial_clk = 1'b1;
         #HALF;
      end
      // Released line shows the inverse; skipped when the next byte follows at once
      if (gap > 0) mosi_in = ~mosi_in;
      #gap;
   endtask

   // data taken on rises, bytes clocked without gaps
   task automatic recv(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         serial_clk = 1'b0;
         #HALF serial_clk = 1'b1;
         b[i] = miso_out;
         #HALF;
      end
   endtask
endmodule // msp_host_model

/* tb/msp_port_asserts.sv */
// Concurrent checks on the motion sensor serial port pins
`timescale 1ns/1ps

module msp_port_asserts
   import msp_pkg::*;
(
   input wire logic     core_clk,         // Core clock
   input wire logic     sys_rst,          // Synchronous reset
   input wire logic     serial_clk,       // Link clock
   input wire logic     chip_select_n,    // Select
   input wire logic     miso_out,         // Device data
   input wire logic     miso_oe,          // Data enable
   input wire logic     motion_n,         // Motion pending
   input wire logic     emitter_enable_n, // Emitter enable
   input wire logic     emitter_drive,    // Emitter drive
   input wire logic     emitter_request,  // Light wanted
   input wire logic     motion_valid,     // New sample
   input wire msp_pwr_t power_state       // Power state
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   oe_follows_select_a: assert property (miso_oe == !chip_select_n)
      else $error("data enable does not follow select");
   emitter_pair_a: assert property (emitter_enable_n == emitter_drive)
      else $error("emitter outputs disagree");
   shut_emitter_off_a: assert property (
      $past(power_state) == MSP_PWR_SHUT && power_state == MSP_PWR_SHUT
      |-> emitter_enable_n && emitter_drive) else $error("emitter on in shutdown");
   emitter_cause_a: assert property (!emitter_enable_n |-> $past(emitter_request) &&
      (power_state == MSP_PWR_RUN || $past(power_state) == MSP_PWR_RUN))
      else $error("emitter on without run and request");
   motion_set_a: assert property (
      power_state == MSP_PWR_RUN && motion_valid ##1 power_state == MSP_PWR_RUN |=> !motion_n)
      else $error("motion output not lowered");
   motion_cause_a: assert property ($fell(motion_n) |-> $past(motion_valid, 2))
      else $error("motion output fell without sample");
   motion_frozen_a: assert property (
      $past(power_state) == MSP_PWR_SHUT && power_state == MSP_PWR_SHUT
      |-> $stable(motion_n)) else $error("motion output moved in shutdown");
   shut_exit_run_a: assert property (
      !$past(sys_rst) && $past(power_state) == MSP_PWR_SHUT && power_state != MSP_PWR_SHUT
      |-> power_state == MSP_PWR_RUN) else $error("shutdown left to wrong state");
   miso_hold_a: assert property (
      !chip_select_n && !$past(chip_select_n) && serial_clk && $past(serial_clk)
      |-> $stable(miso_out)) else $error("data output changed while clock high");
endmodule // msp_port_asserts

bind msp_serial_port msp_port_asserts msp_port_asserts_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
   .chip_select_n(chip_select_n), .miso_out(miso_out), .miso_oe(miso_oe),
   .motion_n(motion_n), .emitter_enable_n(emitter_enable_n),
   .emitter_drive(emitter_drive), .emitter_request(emitter_request),
   .motion_valid(motion_valid), .power_state(power_state));

/* tb/msp_serial_port_tb_top.sv */
// Self-checking bench for the motion sensor serial port
`timescale 1ns/1ps

module msp_serial_port_tb_top;
   import msp_pkg::*;
   localparam logic [7:0] PID = 8'h3c; // Arbitrary identification value
   logic       core_clk;
   logic       sys_rst;
   logic       serial_clk, chip_select_n, mosi_in, miso_out, miso_oe, motion_n;
   logic       emitter_enable_n, emitter_drive;
   logic       emitter_request;
   logic       motion_valid;
   msp_delta_t motion_dx, motion_dy;
   msp_byte_t  sq, su, sl, pk;
   msp_pwr_t   power_state;
   int         error_cnt = 0, check_count = 0, seed = 32'h4f21;
   int         acc_x = 0, acc_y = 0, moved = 0, store;
   logic [7:0] q, d;
   logic [7:0] exp_q[$];

   always #10 core_clk = ~core_clk;

   msp_serial_port #(.PRODUCT_ID(PID)) msp_serial_port_i (.core_clk(core_clk),
      .sys_rst(sys_rst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
      .mosi_in(mosi_in), .miso_out(miso_out), .miso_oe(miso_oe), .motion_n(motion_n),
      .emitter_enable_n(emitter_enable_n), .emitter_drive(emitter_drive),
      .emitter_request(emitter_request), .motion_valid(motion_valid),
      .motion_dx(motion_dx), .motion_dy(motion_dy), .surface_quality(sq),
      .shutter_upper(su), .shutter_lower(sl), .peak_pixel(pk), .power_state(power_state));
   msp_host_model msp_host_model_i (.serial_clk(serial_clk),
      .chip_select_n(chip_select_n), .mosi_in(mosi_in),
      .miso_out(miso_oe ? miso_out : !miso_out));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Register write: address with direction bit set, then data
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      msp_host_model_i.frame(1'b0);
      msp_host_model_i.send({1'b1, a}, 0);
      msp_host_model_i.send(v, 400);
      msp_host_model_i.frame(1'b1);
      #400;
   endtask

   task automatic cfg();
      wr(7'h3c, 8'h27);
      wr(7'h22, 8'h0a);
      wr(7'h21, 8'h01);
      wr(7'h3c, 8'h32);
      wr(7'h23, 8'h20);
      wr(7'h3c, 8'h05);
      wr(7'h37, 8'hb9);
   endtask

   // Register read: pause after address so the latch settles
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      msp_host_model_i.frame(1'b0);
      msp_host_model_i.send({1'b0, a}, 400);
      msp_host_model_i.recv(v);
      #200;
      msp_host_model_i.frame(1'b1);
      #400;
   endtask

   // One displacement sample; model accumulates only while running
   task automatic pulse();
      int dx = ($random(seed) & 63) + 1;
      int dy = ($random(seed) & 63) + 1;
      @(posedge core_clk) #2;
      motion_valid = 1'b1;
      motion_dx    = 12'(dx);
      motion_dy    = 12'(dy);
      @(posedge core_clk) #2;
      motion_valid = 1'b0;
      if (power_state === MSP_PWR_RUN) begin
         acc_x += dx;
         acc_y += dy;
         moved = 1;
      end
      #100;
   endtask

   // Hang guard counts as a failure
   initial begin
      #400_000;
      error_cnt++;
      finish_test();
   end

   initial begin
      core_clk        = 1'b0;
      sys_rst         = 1'b1;
      emitter_request = 1'b0;
      motion_valid    = 1'b0;
      {motion_dx, motion_dy} = 24'($random(seed));
      {sq, su, sl, pk} = $random(seed);
      repeat (5) @(posedge core_clk);
      #2 sys_rst = 1'b0;
      check("motion_n", motion_n, 1);
      check("emitter", emitter_enable_n, 1);
      check("power", power_state, MSP_PWR_UNINIT);
      check("oe", miso_oe, 0);
      emitter_request = 1'b1;
      pulse();
      check("motion_n uninit", motion_n, 1);
      wr(7'h3a, 8'h5a);
      check("power", power_state, MSP_PWR_RUN);
      check("emitter", emitter_enable_n, 0);
      wr(7'h2e, 8'h00);
      cfg();
      rd(7'h00, q);
      check("product", q, PID);
      // Plain storage registers round trip
      foreach (exp_q[i]) exp_q.delete();
      for (int a = 7'h2e; a < 7'h31; a++) begin
         store = $random(seed) & 255;
         wr(7'(a), 8'(store));
         rd(7'(a), q);
         check("storage", q, 8'(store));
      end
      // Abort between address and data leaves the register untouched
      msp_host_model_i.frame(1'b0);
      msp_host_model_i.send(8'hb0, 0);
      msp_host_model_i.frame(1'b1);
      #400;
      rd(7'h30, q);
      check("abort", q, 8'(store));
      pulse();
      pulse();
      check("motion_n set", motion_n, 0);
      rd(7'h02, q);
      check("status", q, 8'h80);
      rd(7'h03, q);
      check("dx", q, 8'(acc_x));
      check("motion_n half", motion_n, 0);
      rd(7'h04, q);
      check("dy", q, 8'(acc_y));
      check("motion_n clear", motion_n, 1);
      acc_x = 0;
      acc_y = 0;
      pulse();
      wr(7'h02, 8'($random(seed)));
      acc_x = 0;
      acc_y = 0;
      check("motion_n wr", motion_n, 1);
      rd(7'h03, q);
      check("dx cleared", q, 8'h00);
      // Burst: status latched at the address, then eight bytes in fixed order
      @(posedge core_clk) #2;
      {sq, su, sl, pk} = $random(seed);
      pulse();
      exp_q = '{8'h80, 8'(acc_x), 8'(acc_y), {4'(acc_x >> 8), 4'(acc_y >> 8)}, sq, su, sl, pk};
      msp_host_model_i.frame(1'b0);
      msp_host_model_i.send(8'h42, 400);
      for (int i = 0; i < 8; i++) begin
         msp_host_model_i.recv(q);
         check("burst", q, exp_q[i]);
      end
      // Shutdown write after the finished burst, before select goes high, must be refused
      msp_host_model_i.send(8'hbb, 0);
      msp_host_model_i.send(8'he7, 400);
      msp_host_model_i.frame(1'b1);
      #400;
      check("burst lock", power_state, MSP_PWR_RUN);
      check("burst clear", motion_n, 1);
      // Burst cut short after delta X, port usable again
      msp_host_model_i.frame(1'b0);
      msp_host_model_i.send(8'h42, 400);
      msp_host_model_i.recv(q);
      msp_host_model_i.recv(q);
      msp_host_model_i.frame(1'b1);
      #400;
      rd(7'h00, q);
      check("after cut", q, PID);
      wr(7'h3b, 8'he7);
      check("shutdown", power_state, MSP_PWR_SHUT);
      check("emitter off", emitter_drive, 1);
      wr(7'h30, 8'(~store));
      pulse();
      check("frozen", motion_n, 1);
      wr(7'h3a, 8'h5a);
      check("wake", power_state, MSP_PWR_RUN);
      // init write and seven configuration writes repeated on leaving shutdown
      cfg();
      rd(7'h30, q);
      check("ignored wr", q, 8'(store));
      finish_test();
   end
endmodule // msp_serial_port_tb_top
